// [common/tccu_pkg.sv]
// shared constants and types of the timer capture/compare unit
`default_nettype none
package tccu_pkg;

    // structure
    localparam int unsigned NUM_CH = 2;
    localparam int unsigned ADDR_W = 8;

    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_VALUE1_LO = 6'h15;
    localparam logic [5:0] IDX_VALUE1_HI = 6'h16;
    localparam logic [5:0] IDX_CTRL1 = 6'h17;
    localparam logic [5:0] IDX_CTRL2 = 6'h1d;
    localparam logic [5:0] IDX_VALUE2_LO = 6'h1e;
    localparam logic [5:0] IDX_VALUE2_HI = 6'h1f;
    localparam logic [5:0] IDX_STATUS = 6'h20;

    // control register fields
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_DUTY_LSB = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [5:0] CTRL_WR_MASK = 6'h3f;

    // status register fields
    localparam int unsigned STAT_FLAG_LSB = 0;
    localparam int unsigned STAT_LATCH_LSB = 2;
    localparam int unsigned STAT_PIN_LSB = 4;

    // reset values and prescaler end counts
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [3:0] PRESC_RESET = 4'h0;
    localparam logic [3:0] PRESC4_LAST = 4'h3;
    localparam logic [3:0] PRESC16_LAST = 4'hf;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // mode field codes
    typedef enum logic [3:0] {
        MODE_OFF = 4'h0,
        MODE_CAP_FALL = 4'h4,
        MODE_CAP_RISE = 4'h5,
        MODE_CAP_RISE4 = 4'h6,
        MODE_CAP_RISE16 = 4'h7,
        MODE_CMP_SET = 4'h8,
        MODE_CMP_CLEAR = 4'h9,
        MODE_CMP_SOFT = 4'ha,
        MODE_CMP_TRIG = 4'hb
    } tccu_mode_e;

    // axi4-lite master to slave
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } tccu_axi_req_s;

    // axi4-lite slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tccu_axi_rsp_s;

endpackage
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the capture/compare unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import tccu_pkg::*;
    // unit and model signals
    logic mclk;
    logic rstn;
    tccu_axi_req_s req;
    tccu_axi_rsp_s rsp;
    logic [15:0] tcount;
    logic adc_en;
    logic t_clr;
    logic t_inh;
    logic adc_st;
    logic [1:0] pin;
    logic [1:0] pout;
    logic [1:0] cflag;
    logic run;
    logic load;
    logic [15:0] load_val;
    int miscompares = 0;
    int n_checks = 0;
    int n_clr = 0;
    int n_inh = 0;
    int n_adc = 0;
    ////////////////////////////////////////////////////////////////
    tccu_top uut (.mclk(mclk), .rstn(rstn), .axi_req(req), .axi_rsp(rsp), .timer1_count(tcount),
        .adc_enable(adc_en), .timer1_clear(t_clr), .timer1_flag_inhibit(t_inh), .adc_start(adc_st),
        .pin_in(pin), .pin_out(pout), .chan_flag(cflag));
    tccu_tmr_model tmr (.mclk(mclk), .rstn(rstn), .run(run), .load(load), .load_val(load_val),
        .clear(t_clr), .count(tcount));
    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // trigger pulse tallies
    always @(posedge mclk) begin
        if (t_clr === 1'b1) n_clr++;
        if (t_inh === 1'b1) n_inh++;
        if (adc_st === 1'b1) n_adc++;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [5:0] ctl(input int c);
        return c == 0 ? IDX_CTRL1 : IDX_CTRL2;
    endfunction
    function automatic logic [5:0] vlo(input int c);
        return c == 0 ? IDX_VALUE1_LO : IDX_VALUE2_LO;
    endfunction
    function automatic logic [5:0] vhi(input int c);
        return c == 0 ? IDX_VALUE1_HI : IDX_VALUE2_HI;
    endfunction
    // bus write: both channels offered together, each dropped when taken
    task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge mclk);
        req <= '{awvalid: 1'b1, awaddr: {idx, 2'b00}, wvalid: 1'b1, wdata: {24'h00_0000, d},
            wstrb: 4'hf, bready: 1'b1, default: '0};
        do begin
            @(posedge mclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (req.awvalid || req.wvalid);
        while (rsp.bvalid !== 1'b1) @(posedge mclk);
        check(rsp.bresp, er);
        req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        req.arvalid <= 1'b1;
        req.araddr <= {idx, 2'b00};
        req.rready <= 1'b1;
        do @(posedge mclk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        while (rsp.rvalid !== 1'b1) @(posedge mclk);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        check(d, {24'h00_0000, e});
        check(r, RESP_OKAY);
    endtask
    task automatic ld(input logic [15:0] v);
        @(posedge mclk);
        load <= 1'b1;
        load_val <= v;
        @(posedge mclk);
        load <= 1'b0;
    endtask
    // long low phase lets a falling edge pass the synchroniser
    task automatic pulses(input int c, input int n);
        repeat (n) begin
            pin[c] <= 1'b1;
            repeat (4) @(posedge mclk);
            pin[c] <= 1'b0;
            repeat (6) @(posedge mclk);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        rchk(IDX_CTRL1, CTRL_RESET);
        rchk(IDX_CTRL2, CTRL_RESET);
        wr(IDX_VALUE1_LO, 8'ha5, RESP_OKAY);
        wr(IDX_VALUE1_HI, 8'h5a, RESP_OKAY);
        wr(IDX_VALUE2_LO, 8'hc3, RESP_OKAY);
        wr(IDX_VALUE2_HI, 8'h3c, RESP_OKAY);
        rchk(IDX_VALUE1_LO, 8'ha5);
        rchk(IDX_VALUE1_HI, 8'h5a);
        rchk(IDX_VALUE2_LO, 8'hc3);
        rchk(IDX_VALUE2_HI, 8'h3c);
        wr(IDX_CTRL2, 8'hf0, RESP_OKAY);
        rchk(IDX_CTRL2, 8'h30);
        check({pout, cflag}, 4'h0);
        wr(6'h00, 8'h11, RESP_SLVERR);
        rd(6'h00, d, r);
        check(r, RESP_SLVERR);
        wr(IDX_CTRL2, 8'h00, RESP_OKAY);
    endtask
    // each edge mode, then an unread value overwritten
    task automatic t_capture;
        tccu_mode_e md [4];
        int nd [4];
        logic [15:0] a;
        md = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16};
        nd = '{1, 1, 4, 16};
        for (int c = 0; c < 2; c++) begin
            for (int m = 0; m < 4; m++) begin
                a = {4'(m), 4'(c), 8'h5a};
                wr(ctl(c), 8'h00, RESP_OKAY);
                wr(ctl(c), {4'h0, md[m]}, RESP_OKAY); // pin kept as input
                wr(IDX_STATUS, 8'h03, RESP_OKAY);
                ld(a);
                pulses(c, nd[m] - 1);
                check(cflag[c], 1'b0);
                pulses(c, 1);
                check(cflag[c], 1'b1);
                ld(~a);
                pulses(c, nd[m]);
                rchk(vlo(c), ~a[7:0]);
                rchk(vhi(c), ~a[15:8]);
            end
        end
    endtask
    task automatic t_presc;
        wr(IDX_CTRL1, {4'h0, MODE_CAP_RISE4}, RESP_OKAY);
        pulses(0, 2);
        wr(IDX_CTRL1, 8'h00, RESP_OKAY);
        wr(IDX_CTRL1, {4'h0, MODE_CAP_RISE4}, RESP_OKAY);
        wr(IDX_STATUS, 8'h03, RESP_OKAY);
        pulses(0, 3);
        check(cflag[0], 1'b0);
        pulses(0, 1);
        check(cflag[0], 1'b1);
        wr(IDX_STATUS, 8'h03, RESP_OKAY);
        // two counted edges survive the hop, so the 14th edge captures
        pulses(0, 2);
        wr(IDX_CTRL1, {4'h0, MODE_CAP_RISE16}, RESP_OKAY);
        repeat (3) @(posedge mclk);
        check(cflag[0], 1'b1);
        wr(IDX_STATUS, 8'h03, RESP_OKAY);
        pulses(0, 13);
        check(cflag[0], 1'b0);
        pulses(0, 1);
        check(cflag[0], 1'b1);
        wr(IDX_CTRL1, 8'h00, RESP_OKAY);
    endtask
    task automatic t_compare;
        tccu_mode_e md [4];
        logic pe [4];
        int k;
        md = '{MODE_CMP_SET, MODE_CMP_SOFT, MODE_CMP_CLEAR, MODE_CMP_SET};
        pe = '{1'b1, 1'b1, 1'b0, 1'b1};
        for (int c = 0; c < 2; c++) begin
            wr(vlo(c), 8'h40, RESP_OKAY);
            wr(vhi(c), 8'h00, RESP_OKAY);
            for (int i = 0; i < 4; i++) begin
                wr(ctl(c), {4'h0, md[i]}, RESP_OKAY); // pin taken as output
                wr(IDX_STATUS, 8'h03, RESP_OKAY);
                ld(16'h0000);
                run <= 1'b1;
                k = 0;
                while (cflag[c] !== 1'b1 && k < 300) begin
                    @(posedge mclk);
                    k++;
                end
                run <= 1'b0;
                check(cflag[c], 1'b1);
                check(pout[c], pe[i]);
            end
            wr(ctl(c), 8'h00, RESP_OKAY);
            repeat (3) @(posedge mclk);
            check(pout[c], 1'b0);
        end
    endtask
    // special trigger with the converter on and off, both channels
    task automatic t_trigger;
        int c0;
        int i0;
        int a0;
        for (int c = 0; c < 2; c++) begin
            for (int e = 0; e < 2; e++) begin
                ld(16'h0000);
                wr(vlo(c), 8'h20, RESP_OKAY);
                wr(vhi(c), 8'h00, RESP_OKAY);
                wr(ctl(c), {4'h0, MODE_CMP_TRIG}, RESP_OKAY);
                adc_en <= e[0];
                c0 = n_clr;
                i0 = n_inh;
                a0 = n_adc;
                run <= 1'b1;
                repeat (100) @(posedge mclk);
                run <= 1'b0;
                check(tcount <= 16'h0028, 1'b1);
                wr(ctl(c), 8'h00, RESP_OKAY);
                check(n_clr - c0 > 1, 1'b1);
                check(n_inh != i0, c[0]);
                check(n_adc != a0, c[0] & e[0]);
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        req = '0;
        pin = 2'b00;
        adc_en = 1'b0;
        run = 1'b0;
        load = 1'b0;
        load_val = 16'h0000;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        repeat (2) @(posedge mclk);
        t_regs;
        t_capture;
        t_presc;
        t_compare;
        t_trigger;
        stop_test;
    end
    // hang guard, far beyond the few thousand cycles expected
    initial begin
        repeat (40000) @(posedge mclk);
        miscompares++;
        stop_test;
    end
endmodule // tb_top
`default_nettype wire

// [dv/tccu_checker.sv]
// port assertions for the capture/compare unit
`timescale 1ns/10ps
`default_nettype none
module tccu_checker
    import tccu_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register bus
    input wire tccu_axi_req_s axi_req,
    input wire tccu_axi_rsp_s axi_rsp,
    // timer side
    input wire logic [15:0] timer1_count,
    input wire logic adc_enable,
    input wire logic timer1_clear,
    input wire logic timer1_flag_inhibit,
    input wire logic adc_start,
    // pins and flags
    input wire logic [NUM_CH-1:0] pin_in,
    input wire logic [NUM_CH-1:0] pin_out,
    input wire logic [NUM_CH-1:0] chan_flag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    // a flag may only drop a few cycles after a status write
    logic [2:0] st_wr;
    always_ff @(posedge mclk) begin
        if (!rstn) st_wr <= 3'h0;
        else if (axi_req.awvalid && axi_rsp.awready && axi_req.awaddr == {IDX_STATUS, 2'b00}) st_wr <= 3'h5;
        else if (st_wr != 3'h0) st_wr <= st_wr - 3'h1;
    end
    ////////////////////////////////////////////////////////////////
    a_inhibit_clear: assert property (timer1_flag_inhibit |-> timer1_clear)
        else $error("inhibit without clear");
    a_adc_from_two: assert property (adc_start |-> timer1_flag_inhibit)
        else $error("conversion start not from channel two");
    a_clear_pulse: assert property (timer1_clear |=> !timer1_clear)
        else $error("timer clear longer than one cycle");
    a_flag_sticky: assert property (|($past(chan_flag) & ~chan_flag) |-> st_wr != 3'h0)
        else $error("flag dropped without software clear");
    a_pin_flag_one: assert property ($rose(pin_out[0]) |-> chan_flag[0])
        else $error("pin rose without flag");
    a_pin_flag_two: assert property ($rose(pin_out[1]) |-> chan_flag[1])
        else $error("pin rose without flag");
    a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
        |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
        else $error("write answer late");
    a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid
        && axi_rsp.rdata[31:8] == 24'h00_0000)
        else $error("read answer late or wide");
    a_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write response dropped");
endmodule // tccu_checker

bind tccu_top tccu_checker chk (.mclk(mclk), .rstn(rstn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .timer1_count(timer1_count), .adc_enable(adc_enable), .timer1_clear(timer1_clear),
    .timer1_flag_inhibit(timer1_flag_inhibit), .adc_start(adc_start), .pin_in(pin_in),
    .pin_out(pin_out), .chan_flag(chan_flag));
`default_nettype wire

// [dv/tccu_tmr_model.sv]
// timer1 stand-in: synchronous count, bench load, cleared by trigger
`timescale 1ns/10ps
`default_nettype none
module tccu_tmr_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // bench control
    input wire logic run,
    input wire logic load,
    input wire logic [15:0] load_val,
    // unit side
    input wire logic clear,
    output logic [15:0] count
);
    // stopping the count keeps capture values predictable
    always_ff @(posedge mclk) begin
        if (!rstn) count <= 16'h0000;
        else if (clear) count <= 16'h0000;
        else if (load) count <= load_val;
        else if (run) count <= count + 16'h0001;
    end
endmodule // tccu_tmr_model
`default_nettype wire

// [src/tccu_top.sv]
// two-channel capture/compare unit on timer1 with an axi4-lite register port
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module tccu_top
    import tccu_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register bus
    input wire tccu_axi_req_s axi_req,
    output tccu_axi_rsp_s axi_rsp,
    // timer1 and converter side
    input wire logic [15:0] timer1_count,
    input wire logic adc_enable,
    output logic timer1_clear,
    output logic timer1_flag_inhibit,
    output logic adc_start,
    // channel pins and flags
    input wire logic [NUM_CH-1:0] pin_in,
    output logic [NUM_CH-1:0] pin_out,
    output logic [NUM_CH-1:0] chan_flag
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0] ctrl [NUM_CH];
    logic [15:0] value [NUM_CH];
    logic [NUM_CH-1:0] flag;
    logic [NUM_CH-1:0] latch;
    logic [NUM_CH-1:0] pin_meta;
    logic [NUM_CH-1:0] pin_sync;
    logic [NUM_CH-1:0] pin_prev;
    logic [NUM_CH-1:0] trig;

    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;

    logic aw_held;
    logic w_held;
    logic [5:0] aw_idx;
    logic [7:0] wbyte;
    logic wlane0;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_fire;
    logic next_aw_held;
    logic next_w_held;
    logic next_bvalid;
    logic next_rvalid;

    logic [NUM_CH-1:0] wr_lo;
    logic [NUM_CH-1:0] wr_hi;
    logic [NUM_CH-1:0] wr_ctl;
    logic [NUM_CH-1:0] clr_flag;
    logic wr_ok;
    logic [31:0] rd_data;
    logic rd_ok;

    ////////////////////////////////////////////////////////////////////////
    // bus handshakes

    assign aw_hs = axi_req.awvalid & awready;
    assign w_hs = axi_req.wvalid & wready;
    assign ar_hs = axi_req.arvalid & arready;
    // a write lands once both halves are held and no answer is pending
    assign wr_fire = aw_held & w_held & ~bvalid;
    assign next_aw_held = (aw_held | aw_hs) & ~wr_fire;
    assign next_w_held = (w_held | w_hs) & ~wr_fire;
    assign next_bvalid = wr_fire | (bvalid & ~axi_req.bready);
    assign next_rvalid = ar_hs | (rvalid & ~axi_req.rready);

    assign axi_rsp.awready = awready;
    assign axi_rsp.wready = wready;
    assign axi_rsp.bvalid = bvalid;
    assign axi_rsp.bresp = bresp;
    assign axi_rsp.arready = arready;
    assign axi_rsp.rvalid = rvalid;
    assign axi_rsp.rdata = rdata;
    assign axi_rsp.rresp = rresp;

    // write address and data capture, taken in either order
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            aw_idx <= 6'h00;
            wbyte <= 8'h00;
            wlane0 <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            // ready drops while a half is held so the master sees back-pressure
            awready <= ~next_aw_held & ~next_bvalid;
            wready <= ~next_w_held & ~next_bvalid;
            if (aw_hs) begin
                aw_idx <= axi_req.awaddr[7:2];
            end
            if (w_hs) begin
                wbyte <= axi_req.wdata[7:0];
                wlane0 <= axi_req.wstrb[0];
            end
        end
    end

    // write response
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            bvalid <= next_bvalid;
            if (wr_fire) begin
                bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // read channel; data is sampled at the address handshake
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else begin
            arready <= ~next_rvalid;
            rvalid <= next_rvalid;
            if (ar_hs) begin
                rdata <= rd_data;
                rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode

    // write strobes; only byte lane 0 carries register data
    always_comb begin
        wr_lo = '0;
        wr_hi = '0;
        wr_ctl = '0;
        clr_flag = '0;
        wr_ok = 1'b1;
        if (wr_fire) begin
            case (aw_idx)
                IDX_VALUE1_LO: wr_lo[0] = wlane0;
                IDX_VALUE1_HI: wr_hi[0] = wlane0;
                IDX_CTRL1: wr_ctl[0] = wlane0;
                IDX_VALUE2_LO: wr_lo[1] = wlane0;
                IDX_VALUE2_HI: wr_hi[1] = wlane0;
                IDX_CTRL2: wr_ctl[1] = wlane0;
                // write one to clear a flag
                IDX_STATUS: clr_flag = wlane0 ? wbyte[STAT_FLAG_LSB +: NUM_CH] : '0;
                default: wr_ok = 1'b0;
            endcase
        end
    end

    // read mux; narrow registers sit in the low byte, the rest reads zero
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        case (axi_req.araddr[7:2])
            IDX_VALUE1_LO: rd_data[7:0] = value[0][7:0];
            IDX_VALUE1_HI: rd_data[7:0] = value[0][15:8];
            IDX_CTRL1: rd_data[7:0] = ctrl[0];
            IDX_VALUE2_LO: rd_data[7:0] = value[1][7:0];
            IDX_VALUE2_HI: rd_data[7:0] = value[1][15:8];
            IDX_CTRL2: rd_data[7:0] = ctrl[1];
            IDX_STATUS: begin
                rd_data[STAT_FLAG_LSB +: NUM_CH] = flag;
                rd_data[STAT_LATCH_LSB +: NUM_CH] = latch;
                rd_data[STAT_PIN_LSB +: NUM_CH] = pin_sync;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // channels

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        tccu_mode_e mode;
        tccu_mode_e new_mode;
        logic is_cap;
        logic new_cap;
        logic is_cmp;
        logic rise;
        logic fall;
        logic cap_evt;
        logic match;
        logic match_prev;
        logic match_evt;
        logic mode_hop;
        logic [3:0] presc;

        assign mode = tccu_mode_e'(ctrl[i][CTRL_MODE_LSB +: 4]);
        assign new_mode = tccu_mode_e'(wbyte[CTRL_MODE_LSB +: 4]);
        // capture codes are 01xx, compare codes are 1xxx; duty bits play no part
        assign is_cap = (ctrl[i][3:2] == 2'b01);
        assign new_cap = (wbyte[3:2] == 2'b01);
        assign is_cmp = ctrl[i][3];
        // edges come from the synchronised level only
        assign rise = pin_sync[i] & ~pin_prev[i];
        assign fall = ~pin_sync[i] & pin_prev[i];
        // a direct hop between capture settings flags a false capture
        assign mode_hop = wr_ctl[i] & is_cap & new_cap & (new_mode != mode);

        // pin synchroniser; the pin is watched in either direction
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                pin_meta[i] <= 1'b0;
                pin_sync[i] <= 1'b0;
                pin_prev[i] <= 1'b0;
            end else begin
                pin_meta[i] <= pin_in[i];
                pin_sync[i] <= pin_meta[i];
                pin_prev[i] <= pin_sync[i];
            end
        end

        // control register; upper two bits are unimplemented
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                ctrl[i] <= CTRL_RESET;
            end else if (wr_ctl[i]) begin
                ctrl[i] <= {2'b00, wbyte[5:0] & CTRL_WR_MASK};
            end
        end

        // edge prescaler; not cleared on a capture-to-capture hop
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                presc <= PRESC_RESET;
            end else if (!is_cap) begin
                presc <= PRESC_RESET;
            end else if (rise && (mode == MODE_CAP_RISE4 || mode == MODE_CAP_RISE16)) begin
                if ((mode == MODE_CAP_RISE4 && presc >= PRESC4_LAST) || presc == PRESC16_LAST) begin
                    presc <= PRESC_RESET;
                end else begin
                    presc <= presc + 4'h1;
                end
            end
        end

        // qualifying capture event
        always_comb begin
            case (mode)
                MODE_CAP_FALL: cap_evt = fall;
                MODE_CAP_RISE: cap_evt = rise;
                MODE_CAP_RISE4: cap_evt = rise & (presc >= PRESC4_LAST);
                MODE_CAP_RISE16: cap_evt = rise & (presc == PRESC16_LAST);
                default: cap_evt = 1'b0;
            endcase
        end

        // compare; one event per match so a slow timer gives one action
        assign match = is_cmp & (value[i] == timer1_count);
        assign match_evt = match & ~match_prev;
        assign trig[i] = match_evt & (mode == MODE_CMP_TRIG);

        always_ff @(posedge mclk) begin
            if (!rstn) begin
                match_prev <= 1'b0;
            end else begin
                match_prev <= match;
            end
        end

        // value register; a capture beats a software write in the same cycle
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                value[i] <= VALUE_RESET;
            end else if (cap_evt) begin
                value[i] <= timer1_count;
            end else begin
                if (wr_lo[i]) begin
                    value[i][7:0] <= wbyte;
                end
                if (wr_hi[i]) begin
                    value[i][15:8] <= wbyte;
                end
            end
        end

        // channel flag; set wins over a clear in the same cycle
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                flag[i] <= 1'b0;
            end else if (cap_evt || match_evt || mode_hop) begin
                flag[i] <= 1'b1;
            end else if (clr_flag[i]) begin
                flag[i] <= 1'b0;
            end
        end

        // compare output latch, separate from the port data latch
        always_ff @(posedge mclk) begin
            if (!rstn) begin
                latch[i] <= 1'b0;
            end else if (mode == MODE_OFF) begin
                latch[i] <= 1'b0;
            end else if (match_evt && mode == MODE_CMP_SET) begin
                latch[i] <= 1'b1;
            end else if (match_evt && mode == MODE_CMP_CLEAR) begin
                latch[i] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs toward timer1, converter, pins

    // registered so every output comes from a flop; costs one cycle of latency
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            timer1_clear <= 1'b0;
            timer1_flag_inhibit <= 1'b0;
            adc_start <= 1'b0;
        end else begin
            timer1_clear <= |trig;
            timer1_flag_inhibit <= trig[1];
            adc_start <= trig[1] & adc_enable;
        end
    end

    // pin and flag mirrors
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pin_out <= '0;
            chan_flag <= '0;
        end else begin
            pin_out <= latch;
            chan_flag <= flag;
        end
    end

endmodule // tccu_top
`default_nettype wire
